// ### wdt_pkg.sv
package wdt_pkg;
   // Register offsets
   localparam logic [7:0] UNITS_OFS = 8'hf1;
   localparam logic [7:0] VALUE_OFS = 8'hf2;
   localparam logic [7:0] CFG_OFS = 8'hf3;
   localparam logic [7:0] CTRL_OFS = 8'hf4;
   localparam logic [7:0] IRQ_STAT_OFS = 8'hf5;
   localparam logic [7:0] IRQ_MASK_OFS = 8'hf6;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   // Field positions
   localparam int UNITS_SEL_BIT = 7;
   localparam int CFG_GAME_BIT = 0;
   localparam int CFG_KBD_BIT = 1;
   localparam int CFG_MOUSE_BIT = 2;
   localparam int CFG_IND_BIT = 3;
   localparam int CFG_MAP_LSB = 4;
   localparam int CTRL_STAT_BIT = 0;
   localparam int CTRL_TOG_BIT = 1;
   localparam int CTRL_FORCE_BIT = 2;
   localparam int CTRL_KBC_EN_BIT = 3;
   // Interrupt routing codes
   localparam logic [3:0] MAP_OFF = 4'h0;
   localparam logic [3:0] MAP_IRQ1 = 4'h1;
   localparam logic [3:0] MAP_BAD = 4'h2;
   localparam logic [3:0] MAP_IRQ3 = 4'h3;
   localparam logic [3:0] MAP_IRQ15 = 4'hf;
   // Timing
   localparam longint CLK_HZ = 50000000;
   localparam longint HALF_SEC_MS = 500;
   localparam longint HALF_SEC_CYC = CLK_HZ * HALF_SEC_MS / 1000;
   localparam longint SECONDS_PER_MIN = 60;

   typedef struct packed {
      logic game;
      logic kbd;
      logic mouse;
   } activity_s;

   typedef struct packed {
      logic irq1;
      logic irq3;
      logic irq15;
   } host_irq_s;
endpackage

// ### tick_divider.sv
`timescale 1ns/1ns
module tick_divider #(
   parameter int unsigned DIV = 4
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic clr_i,
   output logic tick_o
);
   localparam int W = $clog2(DIV + 1);
   logic [W-1:0] cnt_ff;

   // Refused at elaboration: a zero divide has no tick at all
   if (DIV < 1) begin : g_bad_div
      $error("tick_divider: DIV must be at least 1");
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i || clr_i) begin
         cnt_ff <= '0;
         tick_o <= 1'b0;
      end else if (cnt_ff == W'(DIV - 1)) begin
         cnt_ff <= '0;
         tick_o <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule

// ### rise_detect.sv
`timescale 1ns/1ns
module rise_detect (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic lvl_i,
   output logic pulse_o
);
   logic prev_ff;

   // Self-clearing: one pulse per rising edge, however long the level stays high
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prev_ff <= 1'b0;
         pulse_o <= 1'b0;
      end else begin
         prev_ff <= lvl_i;
         pulse_o <= lvl_i & ~prev_ff;
      end
   end
endmodule

// ### host_watchdog_timer.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module host_watchdog_timer
   import wdt_pkg::*;
#(
   parameter longint SEC_CYCLES = CLK_HZ,
   parameter longint HALF_SEC_CYCLES = HALF_SEC_CYC
) (
   // Clock and resets
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic standby_rst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Device activity
   input wire logic activate_i,
   input wire activity_s activity_i,
   input wire logic kbc_force_output_i,
   // Outputs
   output host_irq_s host_irq_o,
   output logic power_indicator_output_o,
   output logic irq_o
);
   import wdt_pkg::*;

   // Refused at elaboration: below two cycles a second the dividers cannot count
   if (SEC_CYCLES < 2 || HALF_SEC_CYCLES < 1) begin : g_bad_timing
      $error("host_watchdog_timer: bad timing");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] units_ff;
   logic [7:0] value_ff;
   logic [7:0] cfg_ff;
   logic status_ff;
   logic toggle_en_ff;
   logic kbc_en_ff;
   logic [1:0] irq_stat_ff;
   logic [1:0] irq_mask_ff;
   logic [7:0] count_ff;
   logic [5:0] min_cnt_ff;
   logic blink_ff;

   logic wr_units;
   logic wr_value;
   logic wr_cfg;
   logic wr_ctrl;
   logic rd_stat;
   logic force_req;
   logic kbc_pulse;
   logic sec_tick;
   logic half_tick;
   logic unit_tick;
   logic restart;
   logic timeout;
   logic enabled;

   assign wr_units = wr_i && (addr_i == UNITS_OFS);
   assign wr_value = wr_i && (addr_i == VALUE_OFS);
   assign wr_cfg = wr_i && (addr_i == CFG_OFS);
   assign wr_ctrl = wr_i && (addr_i == CTRL_OFS);
   assign rd_stat = rd_i && (addr_i == IRQ_STAT_OFS);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         units_ff <= REG_RESET_VAL;
         value_ff <= REG_RESET_VAL;
         cfg_ff <= REG_RESET_VAL;
      end else begin
         if (wr_units) begin
            units_ff <= {wdata_i[UNITS_SEL_BIT], 7'h00};
         end
         if (wr_value) begin
            value_ff <= wdata_i;
         end
         if (wr_cfg) begin
            cfg_ff <= wdata_i;
         end
      end
   end

   // Control lives on standby supply: main reset leaves it alone
   always_ff @(posedge mclk_i) begin
      if (standby_rst_i) begin
         toggle_en_ff <= 1'b0;
         kbc_en_ff <= 1'b0;
      end else if (wr_ctrl) begin
         if (activate_i) begin
            toggle_en_ff <= wdata_i[CTRL_TOG_BIT];
         end
         kbc_en_ff <= wdata_i[CTRL_KBC_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Force and restart sources
   rise_detect u_kbc_edge (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .lvl_i(kbc_force_output_i),
      .pulse_o(kbc_pulse)
   );

   // Force bit is never stored, so it reads zero and clears itself
   assign force_req = (wr_ctrl && wdata_i[CTRL_FORCE_BIT])
      || (kbc_en_ff && kbc_pulse);

   assign restart = wr_value
      || (activate_i && cfg_ff[CFG_GAME_BIT] && activity_i.game)
      || (activate_i && cfg_ff[CFG_KBD_BIT] && activity_i.kbd)
      || (cfg_ff[CFG_MOUSE_BIT] && activity_i.mouse);

   ////////////////////////////////////////////////////////////////////////////////
   // Unit timebase
   tick_divider #(
      .DIV(int'(SEC_CYCLES))
   ) u_sec (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .clr_i(restart),
      .tick_o(sec_tick)
   );

   always_ff @(posedge mclk_i) begin
      if (rst_i || restart) begin
         min_cnt_ff <= 6'h00;
      end else if (sec_tick) begin
         min_cnt_ff <= (min_cnt_ff == 6'(SECONDS_PER_MIN - 1)) ? 6'h00 : min_cnt_ff + 6'h01;
      end
   end

   assign unit_tick = sec_tick
      && (units_ff[UNITS_SEL_BIT] || min_cnt_ff == 6'(SECONDS_PER_MIN - 1));

   ////////////////////////////////////////////////////////////////////////////////
   // Countdown
   assign enabled = (value_ff != 8'h00);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         count_ff <= 8'h00;
      end else if (restart || !enabled) begin
         count_ff <= wr_value ? wdata_i : value_ff;
      end else if (unit_tick && count_ff != 8'h00) begin
         count_ff <= count_ff - 8'h01;
      end
   end

   assign timeout = force_req
      || (enabled && !restart && unit_tick && count_ff == 8'h01);

   // Set wins over a software clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (standby_rst_i) begin
         status_ff <= 1'b0;
      end else if (timeout) begin
         status_ff <= 1'b1;
      end else if (wr_ctrl && activate_i) begin
         status_ff <= wdata_i[CTRL_STAT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Host interrupt routing
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         host_irq_o <= '0;
      end else begin
         host_irq_o.irq1 <= status_ff && cfg_ff[7:CFG_MAP_LSB] == MAP_IRQ1;
         host_irq_o.irq3 <= status_ff && cfg_ff[7:CFG_MAP_LSB] == MAP_IRQ3;
         host_irq_o.irq15 <= status_ff && cfg_ff[7:CFG_MAP_LSB] == MAP_IRQ15;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power indicator blink, free-running half-second phase
   tick_divider #(
      .DIV(int'(HALF_SEC_CYCLES))
   ) u_half (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .clr_i(1'b0),
      .tick_o(half_tick)
   );

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         blink_ff <= 1'b0;
      end else if (half_tick) begin
         blink_ff <= ~blink_ff;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         power_indicator_output_o <= 1'b0;
      end else begin
         power_indicator_output_o <= blink_ff
            && (toggle_en_ff || (cfg_ff[CFG_IND_BIT] && status_ff));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Local interrupt: bit 0 time-out, bit 1 routing code MAP_BAD (4'h2) written
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_stat_ff <= 2'h0;
      end else begin
         irq_stat_ff <= (rd_stat ? 2'h0 : irq_stat_ff)
            | {wr_cfg && wdata_i[7:CFG_MAP_LSB] == MAP_BAD, timeout};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_mask_ff <= 2'h0;
      end else if (wr_i && addr_i == IRQ_MASK_OFS) begin
         irq_mask_ff <= wdata_i[1:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_ff & irq_mask_ff & ~{1'b0, rd_stat}) && !rd_stat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read port
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            UNITS_OFS: rdata_o <= units_ff;
            VALUE_OFS: rdata_o <= value_ff;
            CFG_OFS: rdata_o <= cfg_ff;
            CTRL_OFS: rdata_o <= {4'h0, kbc_en_ff, 1'b0, toggle_en_ff, status_ff};
            IRQ_STAT_OFS: rdata_o <= {6'h00, irq_stat_ff};
            IRQ_MASK_OFS: rdata_o <= {6'h00, irq_mask_ff};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule

// ### host_watchdog_timer_assertions.sv
`timescale 1ns/1ns
module host_watchdog_timer_chk
   import wdt_pkg::*;
#(
   parameter longint HALF_SEC_CYCLES = HALF_SEC_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic standby_rst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Outputs
   input wire host_irq_s host_irq_o,
   input wire logic power_indicator_output_o,
   input wire logic irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] hi_cnt_ff;
   // Length of the lit phase; blink phase is free running, so only bound it
   always_ff @(posedge mclk_i) begin
      if (rst_i || !power_indicator_output_o) begin
         hi_cnt_ff <= 32'h0;
      end else begin
         hi_cnt_ff <= hi_cnt_ff + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   sequence s_rd(logic [7:0] a);
      rd_i && addr_i == a;
   endsequence
   sequence s_rd_unmapped;
      rd_i && !(addr_i inside {[UNITS_OFS:IRQ_MASK_OFS]});
   endsequence
   sequence s_force;
      wr_i && addr_i == CTRL_OFS && wdata_i[CTRL_FORCE_BIT];
   endsequence
   // Nothing in between may clear the flag again
   sequence s_quiet;
      !wr_i && !standby_rst_i;
   endsequence
   property p_force_status;
      s_force ##1 s_quiet ##1 s_rd(CTRL_OFS) |=> rdata_o[CTRL_STAT_BIT];
   endproperty
   property p_route_onehot; $onehot0(host_irq_o); endproperty
   property p_reset_quiet; $fell(rst_i) |-> !irq_o && host_irq_o == '0; endproperty
   property p_units_field; s_rd(UNITS_OFS) |=> rdata_o[6:0] == 7'h00; endproperty
   property p_force_reads0; s_rd(CTRL_OFS) |=> !rdata_o[2] && rdata_o[7:4] == 4'h0; endproperty
   property p_stat_field; s_rd(IRQ_STAT_OFS) |=> rdata_o[7:2] == 6'h00; endproperty
   property p_unmapped; s_rd_unmapped |=> rdata_o == 8'h00; endproperty
   property p_idle_zero; !rd_i |=> rdata_o == 8'h00; endproperty
   property p_blink_on; power_indicator_output_o |-> hi_cnt_ff < HALF_SEC_CYCLES; endproperty
   a_route_onehot: assert property (p_route_onehot)
      else $error("more than one host interrupt line raised");
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("interrupt outputs not clear after reset");
   a_units_field: assert property (p_units_field)
      else $error("units register low bits not zero");
   a_force_reads0: assert property (p_force_reads0)
      else $error("control force or upper bits read nonzero");
   a_stat_field: assert property (p_stat_field)
      else $error("interrupt status upper bits nonzero");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");
   a_idle_zero: assert property (p_idle_zero)
      else $error("read data present without a read");
   a_blink_on: assert property (p_blink_on)
      else $error("indicator lit longer than half a second");
   a_force_status: assert property (p_force_status)
      else $error("status flag not set after a forced time-out");
endmodule
bind host_watchdog_timer host_watchdog_timer_chk #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) chk_u (
   .mclk_i(mclk_i), .rst_i(rst_i), .standby_rst_i(standby_rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .host_irq_o(host_irq_o), .power_indicator_output_o(power_indicator_output_o), .irq_o(irq_o));

// ### test_host_watchdog_timer.sv
`timescale 1ns/1ns
module test_host_watchdog_timer;
   import wdt_pkg::*;
   logic mclk_i = 0, rst_i = 1, standby_rst_i = 1, wr_i = 0, rd_i = 0;
   logic activate_i = 1, kbc_force_output_i = 0, power_indicator_output_o, irq_o;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
   activity_s activity_i = '0;
   host_irq_s host_irq_o;
   int n_mismatch = 0, num_checks = 0;
   // Short second keeps the minute case near 600 cycles
   host_watchdog_timer #(.SEC_CYCLES(10), .HALF_SEC_CYCLES(5)) dut_u (
      .mclk_i(mclk_i), .rst_i(rst_i), .standby_rst_i(standby_rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .activate_i(activate_i),
      .activity_i(activity_i), .kbc_force_output_i(kbc_force_output_i), .host_irq_o(host_irq_o),
      .power_indicator_output_o(power_indicator_output_o), .irq_o(irq_o));
   initial forever #10 mclk_i = ~mclk_i;
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(nm, e, rdata_o);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic pulse(input activity_s a);
      @(posedge mclk_i);
      activity_i <= a;
      @(posedge mclk_i);
      activity_i <= '0;
   endtask
   task automatic edges(input int lo, input int hi, input string nm);
      logic p;
      int n;
      p = power_indicator_output_o;
      n = 0;
      repeat (40) begin
         @(posedge mclk_i);
         #1 if (power_indicator_output_o !== p) n++;
         p = power_indicator_output_o;
      end
      chk(nm, 8'h01, {7'h0, n >= lo && n <= hi});
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      rchk(UNITS_OFS, 8'h00, "units");
      rchk(VALUE_OFS, 8'h00, "value");
      rchk(CFG_OFS, 8'h00, "cfg");
      rchk(CTRL_OFS, 8'h00, "ctrl");
      wr(8'h10, 8'hff);
      rchk(8'h10, 8'h00, "unmapped");
   endtask
   task automatic t_seconds;
      wr(UNITS_OFS, 8'h80);
      wr(CFG_OFS, 8'h30);
      wr(IRQ_MASK_OFS, 8'h01);
      wr(VALUE_OFS, 8'h02);
      cyc(14);
      rchk(CTRL_OFS, 8'h00, "status early");
      cyc(8);
      rchk(CTRL_OFS, 8'h01, "status 2 s");
      chk("irq3", 8'h02, {5'h0, host_irq_o});
      chk("irq_o", 8'h01, {7'h0, irq_o});
      rchk(UNITS_OFS, 8'h80, "units rb");
      wr(VALUE_OFS, 8'h00);
      wr(CTRL_OFS, 8'h00);
      rchk(IRQ_STAT_OFS, 8'h01, "irq stat");
      cyc(2);
      chk("irq_o clr", 8'h00, {7'h0, irq_o});
   endtask
   task automatic t_minutes;
      wr(UNITS_OFS, 8'h00);
      wr(VALUE_OFS, 8'h01);
      cyc(560);
      rchk(CTRL_OFS, 8'h00, "min early");
      cyc(60);
      rchk(CTRL_OFS, 8'h01, "min done");
      wr(VALUE_OFS, 8'h00);
      wr(CTRL_OFS, 8'h00);
   endtask
   task automatic t_route;
      logic [3:0] code[4] = '{4'hf, 4'h3, 4'h1, 4'h0};
      logic [7:0] lines[4] = '{8'h01, 8'h02, 8'h04, 8'h00};
      for (int i = 0; i < 4; i++) begin
         wr(CFG_OFS, {code[i], 4'h0});
         wr(CTRL_OFS, 8'h04);
         rchk(CTRL_OFS, 8'h01, "forced");
         chk("route", lines[i], {5'h0, host_irq_o});
         wr(CTRL_OFS, 8'h00);
      end
      wr(CFG_OFS, 8'h20);
      rchk(IRQ_STAT_OFS, 8'h03, "bad code");
      // Seconds, so three unit ticks pass with value zero
      wr(UNITS_OFS, 8'h80);
      cyc(30);
      rchk(CTRL_OFS, 8'h00, "disabled");
   endtask
   task automatic t_restart;
      wr(UNITS_OFS, 8'h80);
      wr(CFG_OFS, 8'h07);
      wr(VALUE_OFS, 8'h02);
      for (int i = 0; i < 3; i++) begin
         cyc(12);
         pulse(activity_s'(3'b100 >> i));
      end
      // Past the time-out that a missed mouse restart would give
      cyc(10);
      rchk(CTRL_OFS, 8'h00, "restarted");
      wr(CFG_OFS, 8'h00);
      cyc(1);
      pulse(activity_s'(3'b111));
      cyc(18);
      rchk(CTRL_OFS, 8'h01, "not restarted");
      wr(VALUE_OFS, 8'h00);
      wr(CTRL_OFS, 8'h00);
      @(posedge mclk_i) activate_i <= 1'b0;
      wr(CTRL_OFS, 8'h02);
      rchk(CTRL_OFS, 8'h00, "inactive");
      @(posedge mclk_i) activate_i <= 1'b1;
   endtask
   task automatic t_kbc;
      wr(CTRL_OFS, 8'h08);
      @(posedge mclk_i) kbc_force_output_i <= 1'b1;
      cyc(3);
      rchk(CTRL_OFS, 8'h09, "kbc edge");
      wr(CTRL_OFS, 8'h08);
      cyc(3);
      rchk(CTRL_OFS, 8'h08, "kbc level");
      @(posedge mclk_i) kbc_force_output_i <= 1'b0;
      wr(CTRL_OFS, 8'h00);
      @(posedge mclk_i) kbc_force_output_i <= 1'b1;
      cyc(3);
      rchk(CTRL_OFS, 8'h00, "kbc off");
      @(posedge mclk_i) kbc_force_output_i <= 1'b0;
   endtask
   task automatic t_blink;
      wr(CTRL_OFS, 8'h02);
      edges(7, 9, "toggle");
      wr(CTRL_OFS, 8'h00);
      wr(CFG_OFS, 8'h08);
      edges(0, 0, "no status");
      wr(CTRL_OFS, 8'h04);
      edges(7, 9, "status blink");
      wr(CTRL_OFS, 8'h00);
   endtask
   // Main reset mid-run must spare the control register
   task automatic t_main_reset;
      wr(UNITS_OFS, 8'h80);
      wr(CTRL_OFS, 8'h0a);
      @(posedge mclk_i) rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      rchk(UNITS_OFS, 8'h00, "units rst");
      rchk(CTRL_OFS, 8'h0a, "ctrl kept");
      @(posedge mclk_i) standby_rst_i <= 1'b1;
      @(posedge mclk_i) standby_rst_i <= 1'b0;
      rchk(CTRL_OFS, 8'h00, "ctrl standby");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      standby_rst_i <= 1'b0;
      t_reset();
      t_seconds();
      t_minutes();
      t_route();
      t_restart();
      t_kbc();
      t_blink();
      t_main_reset();
      end_sim();
   end
   // Whole run is near 1000 cycles
   initial begin
      repeat (5000) @(posedge mclk_i);
      n_mismatch++;
      end_sim();
   end
endmodule
